// ---- hw/sts_field_check.sv ----
module sts_field_check (
   input  wire logic [63:0] fieldWords,
   input  wire logic        isWrite,
   input  wire logic        cfgFmt24,
   output logic [15:0]      subCode
);
   import sts_pkg::*;

   // True when both nibbles are decimal and the value lies in range
   function automatic logic bcdIn(input logic [7:0] b, input logic [7:0] lo, input logic [7:0] hi);
      bcdIn = (b[7:4] <= 4'h9) && (b[3:0] <= 4'h9) && (b >= lo) && (b <= hi);
   endfunction : bcdIn

   // Two-digit BCD year divisible by four
   function automatic logic leapYear(input logic [7:0] y);
      if (y[4]) leapYear = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      else leapYear = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
   endfunction : leapYear

   // Last legal day of a month, in BCD
   function automatic logic [7:0] monthDays(input logic [7:0] m, input logic leap);
      case (m)
         8'h02: monthDays = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: monthDays = 8'h30;
         default: monthDays = 8'h31;
      endcase
   endfunction : monthDays

   // Field split of the four words, word 1 in the low bits
   logic [7:0] secs, hund, mins, hours, day, wday, year, month;
   logic       fmt24, pmSel;
   assign secs  = fieldWords[15:8];
   assign hund  = fieldWords[7:0];
   assign fmt24 = fieldWords[31];
   assign pmSel = fieldWords[30];
   assign hours = {2'b00, fieldWords[29:24]};
   assign mins  = fieldWords[23:16];
   assign day   = fieldWords[47:40];
   assign wday  = {4'h0, fieldWords[39:36]};
   assign year  = fieldWords[63:56];
   assign month = fieldWords[55:48];

   // First failing field wins, in the order of the sub-codes
   always_comb begin
      subCode = SUB_NONE;
      if (!bcdIn(year, BCD_ZERO, YEAR_MAX)) subCode = SUB_YEAR;
      else if (!bcdIn(month, BCD_ONE, MONTH_MAX)) subCode = SUB_MONTH;
      else if (!bcdIn(day, BCD_ONE, monthDays(month, leapYear(year)))) subCode = SUB_DAY;
      else if (!bcdIn(wday, BCD_ZERO, WDAY_MAX)) subCode = SUB_WDAY;
      // 24-hour mode forbids the afternoon bit; 12-hour counts 01 to 12
      else if (fmt24 ? (pmSel || !bcdIn(hours, BCD_ZERO, H24_MAX))
                     : !bcdIn(hours, BCD_ONE, H12_MAX)) subCode = SUB_HOUR;
      else if (!bcdIn(mins, BCD_ZERO, SEC_MAX)) subCode = SUB_MIN;
      else if (!bcdIn(secs, BCD_ZERO, SEC_MAX)) subCode = SUB_SEC;
      else if (isWrite && (hund != BCD_ZERO)) subCode = SUB_HUND;
      else if (isWrite && (fieldWords[35:32] != 4'h0)) subCode = SUB_NIB;
      else if (fmt24 != cfgFmt24) subCode = SUB_FMT;
   end
endmodule : sts_field_check

// ---- hw/sts_mem_port.sv ----
module sts_mem_port (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        go,
   input  wire logic        isWrite,
   input  wire logic        isFlag,
   input  wire logic [15:0] hiAddr,
   input  wire logic [15:0] loAddr,
   input  wire logic [15:0] wrWord,
   input  wire logic        memRdValid,
   input  wire logic [15:0] memRdData,
   output logic             memRd,
   output logic             memWr,
   output logic             memByte,
   output logic [15:0]      memAddr,
   output logic [15:0]      memWrData,
   output logic             done,
   output logic [15:0]      rdWord
);
   import sts_pkg::*;

   typedef enum logic [3:0] {
      MP_IDLE  = 4'b0001,
      MP_HWAIT = 4'b0010,
      MP_LREQ  = 4'b0100,
      MP_LWAIT = 4'b1000
   } sts_mp_e;

   typedef struct packed {
      sts_mp_e     state;  // Access sequencer
      logic        rd;     // Read strobe
      logic        wr;     // Write strobe
      logic        bmode;  // Byte access into a flag area
      logic [15:0] addr;   // Word or byte address
      logic [15:0] wdata;  // Write data
      logic [15:0] word;   // Assembled read word
      logic        done;   // One word finished
   } sts_mp_s;

   localparam sts_mp_s MP_RST = '{state: MP_IDLE, default: '0};

   sts_mp_s r, nx;

   // A flag word is two byte accesses, high lane first
   always_comb begin
      nx      = r;
      nx.rd   = 1'b0;
      nx.wr   = 1'b0;
      nx.done = 1'b0;
      case (r.state)
         MP_IDLE: begin
            if (go) begin
               nx.addr  = hiAddr;
               nx.bmode = isFlag;
               nx.wdata = isFlag ? {8'h00, wrWord[15:8]} : wrWord;
               nx.rd    = !isWrite;
               nx.wr    = isWrite;
               if (!isWrite) nx.state = MP_HWAIT;
               else if (isFlag) nx.state = MP_LREQ;
               else nx.done = 1'b1;
            end
         end
         MP_HWAIT: begin
            if (memRdValid) begin
               if (r.bmode) begin
                  nx.word[15:8] = memRdData[7:0];
                  nx.state      = MP_LREQ;
               end else begin
                  nx.word  = memRdData;
                  nx.done  = 1'b1;
                  nx.state = MP_IDLE;
               end
            end
         end
         MP_LREQ: begin
            // Low lane sits four bytes above the high lane
            nx.addr  = loAddr;
            nx.wdata = {8'h00, wrWord[7:0]};
            nx.rd    = !isWrite;
            nx.wr    = isWrite;
            if (isWrite) begin
               nx.done  = 1'b1;
               nx.state = MP_IDLE;
            end else nx.state = MP_LWAIT;
         end
         MP_LWAIT: begin
            if (memRdValid) begin
               nx.word[7:0] = memRdData[7:0];
               nx.done      = 1'b1;
               nx.state     = MP_IDLE;
            end
         end
         default: nx = MP_RST;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) r <= MP_RST;
      else r <= nx;
   end

   assign memRd     = r.rd;
   assign memWr     = r.wr;
   assign memByte   = r.bmode;
   assign memAddr   = r.addr;
   assign memWrData = r.wdata;
   assign done      = r.done;
   assign rdWord    = r.word;
endmodule : sts_mem_port

// ---- hw/sts_pkg.sv ----
package sts_pkg;
   // Command word field positions
   localparam int unsigned   FUNC_MSB    = 15;
   localparam int unsigned   FUNC_LSB    = 12;
   localparam int unsigned   AREA_MSB    = 11;
   localparam int unsigned   AREA_LSB    = 8;
   localparam int unsigned   BLK_MSB     = 7;
   localparam int unsigned   BLK_LSB     = 0;
   // Function numbers
   localparam logic [3:0]    FUNC_SET    = 4'h1;
   localparam logic [3:0]    FUNC_GET    = 4'h2;
   // Memory area types
   localparam logic [3:0]    AREA_ORD    = 4'h1;
   localparam logic [3:0]    AREA_EXT    = 4'h2;
   localparam logic [3:0]    AREA_PRI    = 4'h3;
   localparam logic [3:0]    AREA_SEC    = 4'h4;
   // Limits on block number, index and block length
   localparam logic [7:0]    BLK_MIN     = 8'h03;
   localparam logic [15:0]   IDX_MAX_BLK = 16'h07FC;
   localparam logic [15:0]   IDX_MAX_PRI = 16'h00F8;
   localparam logic [15:0]   IDX_MAX_SEC = 16'h03F8;
   localparam logic [15:0]   BLK_LEN_MIN = 16'h0005;
   // Offset of the low byte lane in a flag area
   localparam logic [15:0]   LO_LANE_OFS = 16'h0004;
   localparam logic [1:0]    LAST_WORD   = 2'h3;
   // Error identifiers and sub-codes
   localparam logic [15:0]   ERR_MISSING = 16'h1A07;
   localparam logic [15:0]   ERR_PARAM   = 16'h1A4C;
   localparam logic [15:0]   SUB_NONE    = 16'h0000;
   localparam logic [15:0]   SUB_FUNC    = 16'h0001;
   localparam logic [15:0]   SUB_AREA    = 16'h0100;
   localparam logic [15:0]   SUB_BLOCK   = 16'h0101;
   localparam logic [15:0]   SUB_INDEX   = 16'h0102;
   localparam logic [15:0]   SUB_LEN     = 16'h0103;
   localparam logic [15:0]   SUB_YEAR    = 16'h0201;
   localparam logic [15:0]   SUB_MONTH   = 16'h0202;
   localparam logic [15:0]   SUB_DAY     = 16'h0203;
   localparam logic [15:0]   SUB_WDAY    = 16'h0204;
   localparam logic [15:0]   SUB_HOUR    = 16'h0205;
   localparam logic [15:0]   SUB_MIN     = 16'h0206;
   localparam logic [15:0]   SUB_SEC     = 16'h0207;
   localparam logic [15:0]   SUB_HUND    = 16'h0208;
   localparam logic [15:0]   SUB_NIB     = 16'h0209;
   localparam logic [15:0]   SUB_FMT     = 16'h020A;
   // BCD value limits
   localparam logic [7:0]    BCD_ZERO    = 8'h00;
   localparam logic [7:0]    BCD_ONE     = 8'h01;
   localparam logic [7:0]    SEC_MAX     = 8'h59;
   localparam logic [7:0]    H24_MAX     = 8'h23;
   localparam logic [7:0]    H12_MAX     = 8'h12;
   localparam logic [7:0]    MONTH_MAX   = 8'h12;
   localparam logic [7:0]    YEAR_MAX    = 8'h99;
   localparam logic [7:0]    WDAY_MAX    = 8'h06;
endpackage : sts_pkg

// ---- hw/sts_time_decoder.sv ----
module sts_time_decoder (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        reqStart,
   input  wire logic [15:0] requestCommandWord,
   input  wire logic [15:0] startWordIndex,
   input  wire logic        blockPresent,
   input  wire logic [15:0] blockLength,
   input  wire logic        alarmFmt24,
   input  wire logic        missingHandlerLoaded,
   input  wire logic        paramHandlerLoaded,
   input  wire logic [63:0] timeNow,
   input  wire logic        memRdValid,
   input  wire logic [15:0] memRdData,
   output logic             busy,
   output logic             opDone,
   output logic             clearFlags,
   output logic             accuLoad,
   output logic [15:0]      accu1Value,
   output logic [15:0]      accu2Value,
   output logic             missingBlockHandler,
   output logic             parameterErrorHandler,
   output logic             stopMode,
   output logic             timeSetStrobe,
   output logic [63:0]      timeSetValue,
   output logic [3:0]       memArea,
   output logic [7:0]       memBlock,
   output logic             memRd,
   output logic             memWr,
   output logic             memByte,
   output logic [15:0]      memAddr,
   output logic [15:0]      memWrData
);
   import sts_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_DECODE  = 7'b0000010,
      ST_XFER    = 7'b0000100,
      ST_XWAIT   = 7'b0001000,
      ST_FIELD   = 7'b0010000,
      ST_SUCCESS = 7'b0100000,
      ST_ERROR   = 7'b1000000
   } sts_state_e;

   typedef struct packed {
      sts_state_e       state;  // Request sequencer
      logic [15:0]      cmd;    // Captured command word
      logic [15:0]      idx;    // Captured start-word index
      logic [1:0]       wn;     // Field word being moved
      logic [3:0][15:0] words;  // Time field, word 1 at index 0
      logic [15:0]      code;   // Pending error identifier
      logic [15:0]      sub;    // Pending sub-code
      logic             go;     // Start one word on the memory port
      logic             busy;   // Request in progress
      logic             done;   // Request finished
      logic             clr;    // Clear the three condition flags
      logic             aload;  // Accumulators loaded
      logic [15:0]      accu1;  // Low accumulator image
      logic [15:0]      accu2;  // Second accumulator image
      logic             missH;  // Missing-block handler call
      logic             parH;   // Parameter-error handler call
      logic             stop;   // Stop mode, held until reset
      logic             tset;   // Load the clock from the field
   } sts_core_s;

   localparam sts_core_s CORE_RST = '{state: ST_IDLE, default: '0};

   // Highest legal start index for an area type
   function automatic logic [15:0] idxMax(input logic [3:0] area);
      case (area)
         AREA_ORD, AREA_EXT: idxMax = IDX_MAX_BLK;
         AREA_PRI: idxMax = IDX_MAX_PRI;
         default: idxMax = IDX_MAX_SEC;
      endcase
   endfunction : idxMax

   // Command checks that need no outside answer, first failure wins
   function automatic logic [15:0] cmdSub(input logic [15:0] c, input logic [15:0] x);
      logic [3:0] fnc;
      logic [3:0] area;
      logic       blkArea;
      fnc     = c[FUNC_MSB:FUNC_LSB];
      area    = c[AREA_MSB:AREA_LSB];
      blkArea = (area == AREA_ORD) || (area == AREA_EXT);
      if ((fnc != FUNC_SET) && (fnc != FUNC_GET)) cmdSub = SUB_FUNC;
      else if ((area < AREA_ORD) || (area > AREA_SEC)) cmdSub = SUB_AREA;
      else if (blkArea && (c[BLK_MSB:BLK_LSB] < BLK_MIN)) cmdSub = SUB_BLOCK;
      else if (x > idxMax(area)) cmdSub = SUB_INDEX;
      else cmdSub = SUB_NONE;
   endfunction : cmdSub

   sts_core_s   r, nx;
   logic [3:0]  areaNow;     // Area type of the captured request
   logic        blkArea;     // Data block area, block number matters
   logic        isFlag;      // Flag area, byte-wide accesses
   logic        isGet;       // Read request: clock into memory
   logic [15:0] decodeSub;   // Command check result
   logic [15:0] fieldSub;    // Time field check result
   logic [15:0] hiAddr;      // Word address or high-lane byte
   logic [15:0] loAddr;      // Low-lane byte in a flag area
   logic        mpDone;      // Memory port finished a word
   logic [15:0] mpWord;      // Word fetched by the memory port

   assign areaNow   = r.cmd[AREA_MSB:AREA_LSB];
   assign blkArea   = (areaNow == AREA_ORD) || (areaNow == AREA_EXT);
   assign isFlag    = (areaNow == AREA_PRI) || (areaNow == AREA_SEC);
   assign isGet     = r.cmd[FUNC_MSB:FUNC_LSB] == FUNC_GET;
   assign decodeSub = cmdSub(r.cmd, r.idx);
   assign hiAddr    = r.idx + {14'h0000, r.wn};
   assign loAddr    = hiAddr + LO_LANE_OFS;

   // Field checks see the words fetched from memory
   sts_field_check u_check (
      .fieldWords (r.words),
      .isWrite    (!isGet),
      .cfgFmt24   (alarmFmt24),
      .subCode    (fieldSub)
   );

   // Moves one field word per go, split into bytes for flag areas
   sts_mem_port u_port (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .go         (r.go),
      .isWrite    (isGet),
      .isFlag     (isFlag),
      .hiAddr     (hiAddr),
      .loAddr     (loAddr),
      .wrWord     (r.words[r.wn]),
      .memRdValid (memRdValid),
      .memRdData  (memRdData),
      .memRd      (memRd),
      .memWr      (memWr),
      .memByte    (memByte),
      .memAddr    (memAddr),
      .memWrData  (memWrData),
      .done       (mpDone),
      .rdWord     (mpWord)
   );

   // Request sequencer; pulses default low every cycle
   always_comb begin
      nx       = r;
      nx.go    = 1'b0;
      nx.done  = 1'b0;
      nx.clr   = 1'b0;
      nx.aload = 1'b0;
      nx.missH = 1'b0;
      nx.parH  = 1'b0;
      nx.tset  = 1'b0;
      case (r.state)
         ST_IDLE: begin
            // A stopped processor takes no more requests
            if (reqStart && !r.stop) begin
               nx.cmd   = requestCommandWord;
               nx.idx   = startWordIndex;
               nx.busy  = 1'b1;
               nx.state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            nx.wn    = 2'h0;
            nx.code  = ERR_PARAM;
            nx.sub   = decodeSub;
            nx.state = ST_ERROR;
            if (decodeSub == SUB_NONE) begin
               if (blkArea && !blockPresent) begin
                  nx.code = ERR_MISSING;
                  nx.sub  = SUB_NONE;
               end else if (blkArea && (blockLength < BLK_LEN_MIN)) begin
                  nx.sub = SUB_LEN;
               end else begin
                  nx.state = ST_XFER;
                  // Snapshot so the stored words form one consistent time
                  if (isGet) nx.words = timeNow;
               end
            end
         end
         ST_XFER: begin
            nx.go    = 1'b1;
            nx.state = ST_XWAIT;
         end
         ST_XWAIT: begin
            if (mpDone) begin
               if (!isGet) nx.words[r.wn] = mpWord;
               if (r.wn == LAST_WORD) nx.state = isGet ? ST_SUCCESS : ST_FIELD;
               else begin
                  nx.wn    = r.wn + 2'h1;
                  nx.state = ST_XFER;
               end
            end
         end
         ST_FIELD: begin
            // Clock is loaded only once the whole field has passed
            if (fieldSub != SUB_NONE) begin
               nx.code  = ERR_PARAM;
               nx.sub   = fieldSub;
               nx.state = ST_ERROR;
            end else begin
               nx.tset  = 1'b1;
               nx.state = ST_SUCCESS;
            end
         end
         ST_SUCCESS: begin
            // Accumulators untouched, only the three flags cleared
            nx.clr   = 1'b1;
            nx.done  = 1'b1;
            nx.busy  = 1'b0;
            nx.state = ST_IDLE;
         end
         ST_ERROR: begin
            nx.aload = 1'b1;
            nx.accu1 = r.code;
            nx.accu2 = r.sub;
            if (r.code == ERR_MISSING) begin
               if (missingHandlerLoaded) nx.missH = 1'b1;
               else nx.stop = 1'b1;
            end else begin
               if (paramHandlerLoaded) nx.parH = 1'b1;
               else nx.stop = 1'b1;
            end
            nx.done  = 1'b1;
            nx.busy  = 1'b0;
            nx.state = ST_IDLE;
         end
         default: nx = CORE_RST;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) r <= CORE_RST;
      else r <= nx;
   end

   assign busy                  = r.busy;
   assign opDone                = r.done;
   assign clearFlags            = r.clr;
   assign accuLoad              = r.aload;
   assign accu1Value            = r.accu1;
   assign accu2Value            = r.accu2;
   assign missingBlockHandler   = r.missH;
   assign parameterErrorHandler = r.parH;
   assign stopMode              = r.stop;
   assign timeSetStrobe         = r.tset;
   assign timeSetValue          = r.words;
   assign memArea               = areaNow;
   assign memBlock              = r.cmd[BLK_MSB:BLK_LSB];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   func_check_a: assert property ((r.state == ST_DECODE) && (decodeSub == SUB_FUNC)
      |-> ##2 accuLoad && (accu1Value == ERR_PARAM) && (accu2Value == SUB_FUNC))
      else $error("bad function not reported");
   area_check_a: assert property ((r.state == ST_DECODE) && (r.cmd[FUNC_MSB:FUNC_LSB] == FUNC_SET)
      && (areaNow == 4'h0) |-> ##2 accuLoad && (accu2Value == SUB_AREA))
      else $error("bad area not reported");
   block_range_a: assert property ((r.state == ST_DECODE) && (decodeSub != SUB_FUNC)
      && (decodeSub != SUB_AREA) && blkArea && (memBlock < BLK_MIN)
      |-> ##2 accu2Value == SUB_BLOCK)
      else $error("bad block number not reported");
   index_range_a: assert property ((r.state == ST_DECODE) && (decodeSub == SUB_NONE)
      |-> r.idx <= idxMax(areaNow))
      else $error("index beyond area accepted");
   missing_block_a: assert property (accuLoad && (accu1Value == ERR_MISSING)
      |-> (missingBlockHandler || stopMode) && !parameterErrorHandler)
      else $error("missing block handler not raised");
   stop_absent_a: assert property ($rose(accuLoad) && (accu1Value == ERR_PARAM) && !$past(paramHandlerLoaded)
      |-> stopMode && !parameterErrorHandler)
      else $error("absent handler did not stop");
   success_clean_a: assert property (clearFlags |-> !accuLoad && !missingBlockHandler
      && !parameterErrorHandler && $stable(accu1Value))
      else $error("success disturbed the accumulators");
   no_set_error_a: assert property (timeSetStrobe |-> ##1 clearFlags && !accuLoad)
      else $error("clock loaded without clean finish");
   keep_time_a: assert property ((r.state == ST_FIELD) && (fieldSub != SUB_NONE)
      |-> ##1 !timeSetStrobe ##1 accuLoad && !timeSetStrobe)
      else $error("rejected write loaded the clock");
   word_window_a: assert property (memWr && !memByte
      |-> (memAddr >= r.idx) && (memAddr <= r.idx + 16'h0003))
      else $error("read result stored outside the field");
   flag_lane_a: assert property ((memRd || memWr) && memByte
      |-> (memAddr >= r.idx) && (memAddr <= r.idx + 16'h0007))
      else $error("flag access outside the field bytes");

   set_ok_c: cover property (timeSetStrobe ##1 clearFlags);
   read_ok_c: cover property (isGet && clearFlags);
   param_err_c: cover property (parameterErrorHandler);
   missing_c: cover property (missingBlockHandler);
endmodule : sts_time_decoder

// ---- tb/sts_mem_model.sv ----
// Behavioural data memory standing where the user program's data lives
module sts_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        memRd,
   input  wire logic        memWr,
   input  wire logic        memByte,
   input  wire logic [15:0] memAddr,
   input  wire logic [15:0] memWrData,
   output logic             memRdValid,
   output logic [15:0]      memRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:4095]; // Word store, flag bytes sit in the low lane
   initial memRdValid = 1'b0;
   initial memRdData = 16'h0000;
   // One-cycle answer; an idle bus shows inverted data so stale values never match
   always @(posedge ref_clk) begin
      memRdValid <= memRd;
      memRdData  <= memRd ? mem[memAddr[11:0]] : ~memRdData;
      if (memWr) begin
         mem[memAddr[11:0]] <= memByte ? {8'h00, memWrData[7:0]} : memWrData;
      end
   end
endmodule : sts_mem_model

// ---- tb/sts_time_decoder_tb.sv ----
// Request-level bench: each call issues one command and waits for completion
module sts_time_decoder_tb;
   import sts_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, srst = 1, reqStart = 0, blockPresent = 1, alarmFmt24 = 1;
   logic missingHandlerLoaded = 1, paramHandlerLoaded = 1, memRdValid;
   logic [15:0] requestCommandWord = 0, startWordIndex = 0, blockLength = 16'h0010, memRdData;
   logic [63:0] timeNow = 0, timeSetValue;
   logic busy, opDone, clearFlags, accuLoad, missingBlockHandler, parameterErrorHandler, stopMode;
   logic timeSetStrobe, memRd, memWr, memByte;
   logic [15:0] accu1Value, accu2Value, memAddr, memWrData;
   logic [3:0] memArea;
   logic [7:0] memBlock;
   logic sStr, sClr, sPar, sMis; // Pulses seen during the last request
   int fail_count = 0, tests_run = 0, cyc = 0, k;
   localparam logic [15:0] C[8] = '{16'h010A, 16'h150A, 16'h1102, 16'h110A, 16'h130A, 16'h140A, 16'h310A, 16'h100A};
   localparam logic [15:0] X[8] = '{0, 0, 0, 2045, 249, 1017, 0, 0};
   localparam logic [15:0] S[8] = '{SUB_FUNC, SUB_AREA, SUB_BLOCK, SUB_INDEX, SUB_INDEX, SUB_INDEX, SUB_FUNC, SUB_AREA};
   sts_time_decoder i_sts_time_decoder (.ref_clk, .srst, .reqStart, .requestCommandWord, .startWordIndex,
      .blockPresent, .blockLength, .alarmFmt24, .missingHandlerLoaded, .paramHandlerLoaded, .timeNow,
      .memRdValid, .memRdData, .busy, .opDone, .clearFlags, .accuLoad, .accu1Value, .accu2Value,
      .missingBlockHandler, .parameterErrorHandler, .stopMode, .timeSetStrobe, .timeSetValue, .memArea,
      .memBlock, .memRd, .memWr, .memByte, .memAddr, .memWrData);
   sts_mem_model i_sts_mem_model (.ref_clk, .memRd, .memWr, .memByte, .memAddr, .memWrData, .memRdValid, .memRdData);
   always #20 ref_clk = ~ref_clk;
   // Hang guard: the whole sequence needs well under this many cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Issue one request and wait, bounded, for its completion pulse
   // Pulses are gathered once per cycle, 1 ns after the edge, so none is missed or raced
   task automatic run(input logic [15:0] c, input logic [15:0] i);
      int n;
      @(posedge ref_clk); #1;
      requestCommandWord = c; startWordIndex = i; reqStart = 1; {sStr, sClr, sPar, sMis} = 4'h0;
      n = 0;
      do begin
         @(posedge ref_clk); #1 reqStart = 0;
         n++;
         sStr |= timeSetStrobe; sClr |= clearFlags; sPar |= parameterErrorHandler; sMis |= missingBlockHandler;
      end while (opDone !== 1'b1 && n < 400);
      chk(n < 400, 1);
   endtask : run
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (10) @(posedge ref_clk);
      #1 srst = 0;
      chk({busy, stopMode, accu1Value, accu2Value}, 0);
      chk(timeSetValue, 0);
      for (k = 0; k < 8; k++) begin
         run(C[k], X[k]);
         chk({sPar, accuLoad, accu1Value, accu2Value}, {2'b11, ERR_PARAM, S[k]});
      end
      blockPresent = 0; run(16'h110A, 0);
      chk({sMis, accu1Value}, {1'b1, ERR_MISSING});
      chk({memArea, memBlock}, 12'h10A);
      blockPresent = 1; blockLength = 4; run(16'h110A, 0);
      chk(accu2Value, SUB_LEN);
      blockLength = 16'h0010;
      i_sts_mem_model.mem[0] = 16'h0000; i_sts_mem_model.mem[1] = 16'h9130;
      i_sts_mem_model.mem[2] = 16'h2430; i_sts_mem_model.mem[3] = 16'h9310;
      run(16'h110A, 0);
      chk({sStr, sClr}, 2'b11);
      chk(timeSetValue, 64'h9310_2430_9130_0000);
      i_sts_mem_model.mem[0] = 16'h0001; run(16'h110A, 0);
      chk({sStr, sClr, accu2Value}, {2'b00, SUB_HUND});
      // Read lands at word 8 so the field at word 0 survives for the next set
      i_sts_mem_model.mem[0] = 16'h0000; alarmFmt24 = 0; run(16'h210A, 8);
      chk(sClr, 1);
      run(16'h110A, 0);
      chk({sStr, accu2Value}, {1'b0, SUB_FMT});
      alarmFmt24 = 1; timeNow = 64'h9310_2430_9130_2013; run(16'h210A, 4);
      chk(sClr, 1);
      for (k = 0; k < 4; k++) chk(i_sts_mem_model.mem[4 + k], timeNow[16 * k +: 16]);
      run(16'h2300, 248);
      for (k = 0; k < 4; k++) begin
         chk(i_sts_mem_model.mem[248 + k][7:0], timeNow[16 * k + 8 +: 8]);
         chk(i_sts_mem_model.mem[252 + k][7:0], timeNow[16 * k +: 8]);
      end
      paramHandlerLoaded = 0; run(16'h010A, 0);
      chk({sPar, stopMode}, 2'b01);
      @(posedge ref_clk); #1 reqStart = 1;
      @(posedge ref_clk); #1 reqStart = 0;
      @(posedge ref_clk); #1 chk(busy, 0);
      print_verdict();
   end
endmodule : sts_time_decoder_tb
